// ==== dbgsvc_cfg.svh ====
// constants for the debug channel and memory checksum block
`ifndef DBGSVC_CFG_SVH
`define DBGSVC_CFG_SVH
`define DBGSVC_CRC_POLY    32'hedb88320
`define DBGSVC_CRC_RST     32'h00000000
`define DBGSVC_CH_RST      32'h00000000
`define DBGSVC_DAL_EXIT    2'h2
`define DBGSVC_KEY_W       128
`define DBGSVC_KEY_ROW_LSB 512
`define DBGSVC_KEY_ROW_MSB 639
`define DBGSVC_WORD_STEP   32'h00000004
`define DBGSVC_WORD_LSB    2
`endif

// ==== dbgsvc_pkg.sv ====
// shared types of the debug channel and memory checksum block
package dbgsvc_pkg;
  typedef logic [31:0] dbgsvc_word_t;           // data and address word
  typedef logic [29:0] dbgsvc_cnt_t;            // remaining word count
  typedef enum logic [1:0] {
    DBGSVC_IDLE = 2'b00,                        // waiting for a start
    DBGSVC_BUSY = 2'b01                         // fetching and folding words
  } dbgsvc_state_t;
endpackage

// ==== dbgsvc_crc_if.sv ====
// carrier between the channel logic and the checksum engine
`timescale 1ns/1ps
interface dbgsvc_crc_if;
  import dbgsvc_pkg::*;
  logic         start;      // begin a check
  logic         clr;        // abort and clear status
  dbgsvc_word_t addr;       // first byte address
  dbgsvc_word_t size;       // length in bytes
  logic         seed_wr;    // load the data register
  dbgsvc_word_t seed;       // value for the data register
  logic         busy;       // check running
  logic         done;       // check finished
  logic         bus_error_flag;       // bus error seen
  dbgsvc_word_t result;     // data register
  logic         mem_req;    // read request level
  dbgsvc_word_t mem_addr;   // read address
  logic         mem_ack;    // read answer pulse
  logic         mem_err;    // read answer is an error
  dbgsvc_word_t mem_rdata;  // read data
  modport ctl (output start, clr, addr, size, seed_wr, seed, mem_ack, mem_err, mem_rdata,
               input busy, done, bus_error_flag, result, mem_req, mem_addr);
  modport eng (input start, clr, addr, size, seed_wr, seed, mem_ack, mem_err, mem_rdata,
               output busy, done, bus_error_flag, result, mem_req, mem_addr);
endinterface

// ==== dbgsvc_crc.sv ====
// crc32 memory checksum engine, one word per read answer
`timescale 1ns/1ps
`include "dbgsvc_cfg.svh"
module dbgsvc_crc (
  input wire logic clk,
  input wire logic rst_n,
  dbgsvc_crc_if.eng ifc
);
  import dbgsvc_pkg::*;

  dbgsvc_state_t st_q, st_d;        // engine state
  dbgsvc_word_t  addr_q, addr_d;    // next read address
  dbgsvc_cnt_t   left_q, left_d;    // words still to fold
  dbgsvc_word_t  crc_q, crc_d;      // running checksum, also the data register
  logic          done_q, done_d;    // completion flag
  logic          bus_error_flag_q, bus_error_flag_d;    // bus error flag
  logic          req_q, req_d;      // read request

  // reflected crc32 over one little-endian word, no final inversion
  function automatic dbgsvc_word_t crc_step(input dbgsvc_word_t c, input dbgsvc_word_t d);
    dbgsvc_word_t r;
    r = c;
    for (int i = 0; i < 32; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `DBGSVC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // next-state logic; abort beats everything, a start while busy is ignored
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    left_d = left_q;
    crc_d  = crc_q;
    done_d = done_q;
    bus_error_flag_d = bus_error_flag_q;
    req_d  = req_q;
    if (ifc.clr) begin                                    // [R2]
      st_d   = DBGSVC_IDLE;
      req_d  = 1'b0;
      done_d = 1'b0;
      bus_error_flag_d = 1'b0;
    end else begin
      unique case (st_q)
        DBGSVC_IDLE: begin
          if (ifc.seed_wr) begin
            crc_d = ifc.seed;                             // seed kept uninverted by software [R3]
          end
          if (ifc.start) begin                            // [R1]
            addr_d = {ifc.addr[31:`DBGSVC_WORD_LSB], 2'b00};
            left_d = ifc.size[31:`DBGSVC_WORD_LSB];
            done_d = 1'b0;                                // stale status dropped [R14]
            bus_error_flag_d = 1'b0;                                // [R14]
            if (ifc.size[31:`DBGSVC_WORD_LSB] == '0) begin
              done_d = 1'b1;                              // empty range finishes at once [R4]
            end else begin
              st_d  = DBGSVC_BUSY;
              req_d = 1'b1;
            end
          end
        end
        DBGSVC_BUSY: begin
          if (ifc.mem_ack) begin
            if (ifc.mem_err) begin                        // stop on the first error
              bus_error_flag_d = 1'b1;
              done_d = 1'b1;                              // [R4]
              st_d   = DBGSVC_IDLE;
              req_d  = 1'b0;
            end else begin
              crc_d  = crc_step(crc_q, ifc.mem_rdata);
              addr_d = addr_q + `DBGSVC_WORD_STEP;
              left_d = left_q - 30'h1;
              if (left_q == 30'h1) begin                  // last word folded [R4]
                done_d = 1'b1;
                st_d   = DBGSVC_IDLE;
                req_d  = 1'b0;
              end
            end
          end
        end
        default: begin                                    // unused code, recover
          st_d  = DBGSVC_IDLE;
          req_d = 1'b0;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= DBGSVC_IDLE;
      addr_q <= '0;
      left_q <= '0;
      crc_q  <= `DBGSVC_CRC_RST;
      done_q <= 1'b0;
      bus_error_flag_q <= 1'b0;
      req_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      left_q <= left_d;
      crc_q  <= crc_d;
      done_q <= done_d;
      bus_error_flag_q <= bus_error_flag_d;
      req_q  <= req_d;
    end
  end

  assign ifc.busy     = (st_q == DBGSVC_BUSY);
  assign ifc.done     = done_q;
  assign ifc.bus_error_flag     = bus_error_flag_q;
  assign ifc.result   = crc_q;
  assign ifc.mem_req  = req_q;
  assign ifc.mem_addr = addr_q;

  // checks
  sequence s_last_word;
    st_q == DBGSVC_BUSY && ifc.mem_ack && !ifc.mem_err && left_q == 30'h1 && !ifc.clr;
  endsequence
  sequence s_go;
    st_q == DBGSVC_IDLE && ifc.start && !ifc.clr && ifc.size[31:2] != '0;
  endsequence
  a_start_runs: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    s_go |=> ifc.mem_req && !done_q && !bus_error_flag_q && ifc.mem_addr == $past(ifc.addr) - $past(ifc.addr) % 4)
    else $error("start did not begin a clean run");
  a_abort_stops: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    ifc.clr |=> !ifc.mem_req && !done_q && st_q == DBGSVC_IDLE)
    else $error("abort left the engine running");
  a_last_done: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    s_last_word |=> done_q && !ifc.mem_req ##1 done_q || ifc.clr || ifc.start)
    else $error("completion flag missing after last word");
  a_bus_error_flag_flag: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    st_q == DBGSVC_BUSY && ifc.mem_ack && ifc.mem_err && !ifc.clr |=> bus_error_flag_q && done_q && !ifc.mem_req)
    else $error("bus error not reported");
  a_stale_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    s_go |=> !done_q [*2])
    else $error("stale completion after start");
endmodule

// ==== dbgsvc_top.sv ====
// debug channels, boot channels and memory checksum service logic
`timescale 1ns/1ps
`include "dbgsvc_cfg.svh"
// Function
// [R1] writing the start bit begins crc32
// [R2] software reset aborts a running check
// [R3] reader inverts result; seed stays raw
// [R4] completion flag set when check finishes
// [R5] reader checks bus error after completion
// [R6] two channels, cpu and debugger, unrestricted
// [R7] channels always reachable from debugger side
// [R8] written flag sets on write, clears on read
// [R9] no channel use during memory self-test
// [R10] do not mix debug and boot traffic
// [R11] channels cleared only by power-on/brownout
// [R12] boot exit needs access level two
// [R13] boot checksum needs nonzero matching key
// [R14] start clears old completion and error
module dbgsvc_top #(
  parameter int KEY_W = `DBGSVC_KEY_W
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  NRST,
  input  wire logic                  SYS_NRST,
  input  wire logic                  CPU_WR,
  input  wire logic                  CPU_RD,
  input  wire logic                  CPU_SEL,
  input  dbgsvc_pkg::dbgsvc_word_t   CPU_WDATA,
  input  wire logic                  DBG_WR,
  input  wire logic                  DBG_RD,
  input  wire logic                  DBG_SEL,
  input  dbgsvc_pkg::dbgsvc_word_t   DBG_WDATA,
  output dbgsvc_pkg::dbgsvc_word_t   CH0_DATA,
  output dbgsvc_pkg::dbgsvc_word_t   CH1_DATA,
  output logic                       CH0_WRITTEN,
  output logic                       CH1_WRITTEN,
  input  wire logic                  CRC_START,
  input  wire logic                  SW_RESET,
  input  dbgsvc_pkg::dbgsvc_word_t   CRC_ADDR,
  input  dbgsvc_pkg::dbgsvc_word_t   CRC_SIZE,
  input  wire logic                  SEED_WR,
  input  dbgsvc_pkg::dbgsvc_word_t   SEED_DATA,
  input  wire logic                  BOOT_CRC_CMD,
  input  wire logic [KEY_W-1:0]      BOOT_CRC_KEY,
  input  wire logic [KEY_W-1:0]      ROW_KEY,
  output logic                       CRC_BUSY,
  output logic                       CRC_DONE,
  output logic                       BUS_ERROR,
  output dbgsvc_pkg::dbgsvc_word_t   CRC_DATA,
  output logic                       MEM_REQ,
  output dbgsvc_pkg::dbgsvc_word_t   MEM_ADDR,
  input  wire logic                  MEM_ACK,
  input  wire logic                  MEM_ERR,
  input  dbgsvc_pkg::dbgsvc_word_t   MEM_RDATA,
  input  wire logic                  COLD_PLUG,
  input  wire logic [1:0]            ACCESS_LEVEL,
  input  wire logic                  EXIT_CMD,
  output logic                       CPU_RELEASE,
  output logic                       CMD_REFUSED
);
  import dbgsvc_pkg::*;

  // the key compare is bytewise in the boot row, so only whole bytes make sense
  if (KEY_W < 8 || KEY_W % 8 != 0) begin : g_key_check
    $error("KEY_W must be a positive multiple of 8");
  end

  dbgsvc_crc_if crc ();                    // link to the checksum engine

  dbgsvc_word_t ch0_q, ch0_d;              // channel zero word
  dbgsvc_word_t ch1_q, ch1_d;              // channel one word
  logic         wf0_q, wf0_d;              // channel zero written flag
  logic         wf1_q, wf1_d;              // channel one written flag
  logic         rel_q, rel_d;              // cpu may leave the boot routine
  logic         ref_q, ref_d;              // boot checksum command refused
  logic         key_ok;                    // boot checksum key accepted
  logic         wr0, wr1, rd0, rd1;        // decoded channel strobes

  // decode; both parties reach both channels with no gating at any time [R6] [R7]
  always_comb begin
    wr0 = (CPU_WR && !CPU_SEL) || (DBG_WR && !DBG_SEL);
    wr1 = (CPU_WR &&  CPU_SEL) || (DBG_WR &&  DBG_SEL);
    rd0 = (CPU_RD && !CPU_SEL) || (DBG_RD && !DBG_SEL);
    rd1 = (CPU_RD &&  CPU_SEL) || (DBG_RD &&  DBG_SEL);
  end

  // channel next values; the debugger wins a same-cycle write to one channel
  always_comb begin
    ch0_d = ch0_q;
    ch1_d = ch1_q;
    if (DBG_WR && !DBG_SEL) begin                        // [R6]
      ch0_d = DBG_WDATA;
    end else if (CPU_WR && !CPU_SEL) begin
      ch0_d = CPU_WDATA;
    end
    if (DBG_WR && DBG_SEL) begin                         // [R6]
      ch1_d = DBG_WDATA;
    end else if (CPU_WR && CPU_SEL) begin
      ch1_d = CPU_WDATA;
    end
    // a write in the read cycle keeps the flag up so the new word is not missed
    wf0_d = wr0 ? 1'b1 : (rd0 ? 1'b0 : wf0_q);           // [R8]
    wf1_d = wr1 ? 1'b1 : (rd1 ? 1'b0 : wf1_q);           // [R8]
  end

  // channels double as boot channels, so only the power-on reset clears them
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin                                     // [R11]
      ch0_q <= `DBGSVC_CH_RST;
      ch1_q <= `DBGSVC_CH_RST;
      wf0_q <= 1'b0;
      wf1_q <= 1'b0;
    end else begin
      ch0_q <= ch0_d;
      ch1_q <= ch1_d;
      wf0_q <= wf0_d;
      wf1_q <= wf1_d;
    end
  end

  // boot command checks; an all-zero row key shuts the command off
  always_comb begin
    key_ok = (ROW_KEY != '0) && (BOOT_CRC_KEY == ROW_KEY);        // [R13]
    ref_d  = BOOT_CRC_CMD && !key_ok;                             // [R13]
    rel_d  = rel_q;
    if (!SYS_NRST) begin
      rel_d = 1'b0;                                               // reset re-enters boot
    end else if (!COLD_PLUG) begin
      rel_d = 1'b1;                                               // normal start leaves at once
    end else if (EXIT_CMD && ACCESS_LEVEL == `DBGSVC_DAL_EXIT) begin
      rel_d = 1'b1;                                               // [R12]
    end
    if (!SYS_NRST) begin
      ref_d = 1'b0;
    end
  end

  // boot command registers
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rel_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      rel_q <= rel_d;
      ref_q <= ref_d;
    end
  end

  // engine control; system reset acts like the software reset on the checksum
  assign crc.start     = CRC_START || (BOOT_CRC_CMD && key_ok);   // [R1] [R13]
  assign crc.clr       = SW_RESET || !SYS_NRST;                   // [R2]
  assign crc.addr      = CRC_ADDR;
  assign crc.size      = CRC_SIZE;
  assign crc.seed_wr   = SEED_WR;
  assign crc.seed      = SEED_DATA;
  assign crc.mem_ack   = MEM_ACK;
  assign crc.mem_err   = MEM_ERR;
  assign crc.mem_rdata = MEM_RDATA;

  dbgsvc_crc i_dbgsvc_crc (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .ifc   (crc)
  );

  // outputs, each from a flip-flop here or in the engine
  assign CH0_DATA    = ch0_q;
  assign CH1_DATA    = ch1_q;
  assign CH0_WRITTEN = wf0_q;
  assign CH1_WRITTEN = wf1_q;
  assign CRC_BUSY    = crc.busy;
  assign CRC_DONE    = crc.done;          // status a completion
  assign BUS_ERROR   = crc.bus_error_flag;          // status a bus error, read after completion [R5]
  assign CRC_DATA    = crc.result;        // raw, uninverted [R3]
  assign MEM_REQ     = crc.mem_req;
  assign MEM_ADDR    = crc.mem_addr;
  assign CPU_RELEASE = rel_q;
  assign CMD_REFUSED = ref_q;

  // checks
  sequence s_wr_then_rd0;
    wr0 ##1 (rd0 && !wr0);
  endsequence
  a_flag_set: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R8]
    wr1 |=> CH1_WRITTEN && CH1_DATA == $past(DBG_WR && DBG_SEL ? DBG_WDATA : CPU_WDATA))
    else $error("channel one write not flagged");
  a_flag_clear: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R8]
    s_wr_then_rd0 |=> !CH0_WRITTEN)
    else $error("channel zero read did not clear flag");
  a_ch_holds: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R11]
    !wr0 && !SYS_NRST |=> $stable(CH0_DATA))
    else $error("channel zero lost its word on system reset");
  a_exit_gate: assert property (@(posedge REF_CLK) disable iff (!NRST || !SYS_NRST) // [R12]
    COLD_PLUG && !CPU_RELEASE && !(EXIT_CMD && ACCESS_LEVEL == 2'h2) |=> !CPU_RELEASE)
    else $error("boot exit without access level two");
  a_key_block: assert property (@(posedge REF_CLK) disable iff (!NRST || !SYS_NRST) // [R13]
    BOOT_CRC_CMD && ROW_KEY == '0 && !CRC_START && !CRC_BUSY |=> CMD_REFUSED && !CRC_BUSY)
    else $error("zero key did not block checksum command");
  // an accepted boot command while idle must start a run or finish an empty one at once
  sequence s_key_go;
    BOOT_CRC_CMD && key_ok && !CRC_BUSY && !SW_RESET && SYS_NRST;
  endsequence
  a_key_go: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R13]
    s_key_go |=> CRC_BUSY || CRC_DONE)
    else $error("matching key did not start the checksum");
  // the refusal marker follows the refused command and drops one cycle after the command is withdrawn
  a_refuse_pulse: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R13]
    CMD_REFUSED && !BOOT_CRC_CMD |=> !CMD_REFUSED)
    else $error("refusal marker stuck high");
  // once released the cpu stays released until a reset
  a_release_hold: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R12]
    CPU_RELEASE && SYS_NRST |=> CPU_RELEASE)
    else $error("cpu release dropped without reset");
  // any write to channel zero lands and raises its flag, debugger first
  a_ch0_write: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R8]
    wr0 |=> CH0_WRITTEN && CH0_DATA == $past(DBG_WR && !DBG_SEL ? DBG_WDATA : CPU_WDATA))
    else $error("channel zero write not flagged");
  // system reset stops the checksum engine like the software reset
  a_sys_abort: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R2]
    !SYS_NRST |=> !CRC_BUSY && !MEM_REQ && !CRC_DONE)
    else $error("system reset left the checksum running");
endmodule

// ==== dbgsvc_mem_model.sv ====
// memory responder that answers checksum word reads with a chosen latency
`timescale 1ns/1ps
module dbgsvc_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  delay,
  input  wire logic [31:0] err_addr,
  output logic             ack,
  output logic             err,
  output logic [31:0]      rdata
);
  logic [3:0] cnt_q; // cycles the pending read has waited
  // one answer per read; between answers the data lines flip every cycle between the inverse of the last word and the word,
  // so a design that samples off the answer cycle sees garbage rather than a lucky match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      ack   <= 1'h0;
      err   <= 1'h0;
      rdata <= 32'h0;
    end else if (ack) begin
      cnt_q <= 4'h0;
      ack   <= 1'h0;
      err   <= 1'h0;
      rdata <= ~rdata;
    end else if (req && cnt_q >= delay) begin
      ack   <= 1'h1;
      err   <= (addr == err_addr); // error answer only at the chosen word
      rdata <= {addr[15:0], ~addr[15:0]}; // word content tied to its address
    end else begin
      cnt_q <= req ? cnt_q + 4'h1 : 4'h0;
      rdata <= ~rdata;
    end
  end
endmodule

// ==== test_debug_channels_and_memory_checksum.sv ====
// self-checking bench for the debug channel and memory checksum block
`timescale 1ns/1ps
`include "dbgsvc_cfg.svh"
module test_debug_channels_and_memory_checksum;
  import dbgsvc_pkg::*;
  logic          ref_clk, nrst, sys_nrst, cpu_wr, cpu_rd, cpu_sel, dbg_wr, dbg_rd, dbg_sel;
  logic          crc_start, sw_reset, seed_wr, boot_crc_cmd, cold_plug, exit_cmd, mem_ack, mem_err;
  logic          ch0_written, ch1_written, crc_busy, crc_done, bus_error, mem_req, cpu_release, cmd_refused;
  dbgsvc_word_t  cpu_wdata, dbg_wdata, crc_addr, crc_size, seed_data, ch0_data, ch1_data, crc_data;
  dbgsvc_word_t  mem_addr, mem_rdata, err_addr, last_crc;
  logic [127:0]  boot_crc_key, row_key;
  logic [1:0]    access_level;
  logic [3:0]    delay;
  int            bad_count, check_count;
  dbgsvc_top i_dbgsvc_top (.REF_CLK(ref_clk), .NRST(nrst), .SYS_NRST(sys_nrst), .CPU_WR(cpu_wr),
    .CPU_RD(cpu_rd), .CPU_SEL(cpu_sel), .CPU_WDATA(cpu_wdata), .DBG_WR(dbg_wr), .DBG_RD(dbg_rd),
    .DBG_SEL(dbg_sel), .DBG_WDATA(dbg_wdata), .CH0_DATA(ch0_data), .CH1_DATA(ch1_data),
    .CH0_WRITTEN(ch0_written), .CH1_WRITTEN(ch1_written), .CRC_START(crc_start), .SW_RESET(sw_reset),
    .CRC_ADDR(crc_addr), .CRC_SIZE(crc_size), .SEED_WR(seed_wr), .SEED_DATA(seed_data),
    .BOOT_CRC_CMD(boot_crc_cmd), .BOOT_CRC_KEY(boot_crc_key), .ROW_KEY(row_key), .CRC_BUSY(crc_busy),
    .CRC_DONE(crc_done), .BUS_ERROR(bus_error), .CRC_DATA(crc_data), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr),
    .MEM_ACK(mem_ack), .MEM_ERR(mem_err), .MEM_RDATA(mem_rdata), .COLD_PLUG(cold_plug),
    .ACCESS_LEVEL(access_level), .EXIT_CMD(exit_cmd), .CPU_RELEASE(cpu_release), .CMD_REFUSED(cmd_refused));
  dbgsvc_mem_model i_dbgsvc_mem_model (.clk(ref_clk), .rst_n(nrst), .req(mem_req), .addr(mem_addr),
    .delay(delay), .err_addr(err_addr), .ack(mem_ack), .err(mem_err), .rdata(mem_rdata));
  // 40 MHz reference clock
  always #12.5 ref_clk = ~ref_clk;
  // verdict and end of run
  task automatic test_done();
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // compare one observed value with its expectation
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // reflected crc32 step over one word, low bit first, no final inversion
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    logic b;
    for (int i = 0; i < 32; i++) begin
      b = c[0] ^ w[i];
      c = c >> 1;
      if (b) c = c ^ `DBGSVC_CRC_POLY;
    end
    return c;
  endfunction
  // one channel access cycle from either or both parties
  task automatic ch(input logic cw, cr, dw, dr, sel, input logic [31:0] d);
    @(posedge ref_clk);
    {cpu_wr, cpu_rd, dbg_wr, dbg_rd} <= {cw, cr, dw, dr};
    {cpu_sel, dbg_sel, cpu_wdata, dbg_wdata} <= {sel, sel, ~d, d};
    @(posedge ref_clk);
    {cpu_wr, cpu_rd, dbg_wr, dbg_rd} <= 4'h0;
    #1;
  endtask
  // bounded wait for the completion flag
  task automatic wait_done();
    int n;
    n = 0;
    while (crc_done !== 1'h1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (crc_done !== 1'h1) begin
      chk("done timeout", 32'h0, 32'h1);
      test_done();
    end
  endtask
  // seed, start and finish one checksum run; expectation from the address-tied memory words
  task automatic run_crc(input logic [31:0] seed, a, sz, input logic bus_error_flag);
    logic [31:0] e;
    logic [15:0] w;
    e = seed;
    w = {a[15:2], 2'b00}; // the engine drops the low address bits, so the words come from aligned addresses
    for (int k = 0; k < int'(sz[31:2]); k++) e = crc_word(e, {w + 16'(k * 4), ~(w + 16'(k * 4))});
    @(posedge ref_clk);
    seed_wr <= 1'h1;
    seed_data <= seed;
    @(posedge ref_clk);
    {seed_wr, crc_start, crc_addr, crc_size} <= {1'h0, 1'h1, a, sz};
    @(posedge ref_clk);
    crc_start <= 1'h0;
    #1;
    chk("busy", crc_busy, 32'h1);
    chk("done cleared", crc_done, 32'h0);
    chk("error cleared", bus_error, 32'h0);
    chk("first address", mem_addr, a & ~32'h3);
    wait_done();
    chk("done", crc_done, 32'h1);
    chk("bus error", bus_error, bus_error_flag);
    if (!bus_error_flag) chk("checksum", crc_data, e);
    last_crc = e;
  endtask
  // checksum runs: plain, chained on the raw result, faulted, then a short seeded run and a slow long one
  task automatic t_crc();
    logic [31:0] full;
    run_crc(32'hffffffff, 32'h00000100, 32'h00000010, 1'h0);
    full = last_crc;
    delay <= 4'h3;
    run_crc(32'hffffffff, 32'h00000102, 32'h00000008, 1'h0);
    run_crc(last_crc, 32'h00000108, 32'h0000000b, 1'h0); // raw value reused as seed
    chk("chained checksum", crc_data, full);
    err_addr <= 32'h00000204;
    run_crc(32'hffffffff, 32'h00000200, 32'h00000010, 1'h1);
    run_crc(32'h12345678, 32'h00000200, 32'h00000004, 1'h0);
    delay <= 4'h8;
    run_crc(32'hffffffff, 32'h00000300, 32'h00000040, 1'h0);
  endtask
  // abort a slow run with the software reset bit
  task automatic t_abort();
    @(posedge ref_clk);
    crc_start <= 1'h1;
    @(posedge ref_clk);
    crc_start <= 1'h0;
    repeat (2) @(posedge ref_clk);
    sw_reset <= 1'h1;
    @(posedge ref_clk);
    sw_reset <= 1'h0;
    #1;
    chk("abort busy", crc_busy, 32'h0);
    chk("abort done", crc_done, 32'h0);
    chk("abort request", mem_req, 32'h0);
  endtask
  // boot checksum command against the row key
  task automatic boot_try(input logic [127:0] k, r, input logic ok);
    @(posedge ref_clk);
    {boot_crc_cmd, boot_crc_key, row_key} <= {1'h1, k, r};
    @(posedge ref_clk);
    boot_crc_cmd <= 1'h0;
    #1;
    chk("boot refused", cmd_refused, !ok);
    chk("boot busy", crc_busy, ok);
    if (ok) wait_done();
  endtask
  // boot exit attempt at one access level
  task automatic exit_try(input logic [1:0] lvl, input logic exp);
    @(posedge ref_clk);
    {exit_cmd, access_level} <= {1'h1, lvl};
    @(posedge ref_clk);
    exit_cmd <= 1'h0;
    #1;
    chk("release", cpu_release, exp);
  endtask
  // write channel zero and read it in the very next cycle; the read must drop the flag
  task automatic t_ch_b2b();
    @(posedge ref_clk);
    {dbg_wr, dbg_sel, cpu_sel, dbg_wdata} <= {1'h1, 1'h0, 1'h0, 32'h2468ace0};
    @(posedge ref_clk);
    {dbg_wr, cpu_rd} <= 2'h1;
    @(posedge ref_clk);
    cpu_rd <= 1'h0;
    #1;
    chk("back to back data", ch0_data, 32'h2468ace0);
    chk("back to back flag", ch0_written, 32'h0);
  endtask
  // main sequence; channels serve only as a debug mailbox, no self-test or boot traffic mixed
  initial begin
    {ref_clk, nrst, sys_nrst, cpu_wr, cpu_rd, cpu_sel, dbg_wr, dbg_rd, dbg_sel} = 9'h0;
    {crc_start, sw_reset, seed_wr, boot_crc_cmd, exit_cmd, access_level} = 7'h0;
    {cpu_wdata, dbg_wdata, crc_addr, crc_size, seed_data, boot_crc_key, row_key} = '0;
    {cold_plug, delay, err_addr} = {1'h1, 4'h0, 32'hfffffff0};
    {bad_count, check_count} = 0;
    repeat (16) @(posedge ref_clk);
    {nrst, sys_nrst} <= 2'h3;
    #1;
    chk("reset channel", ch0_data, 32'h0);
    chk("reset flag", ch0_written, 32'h0);
    ch(1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 32'ha1b2c3d4);
    chk("ch0 data", ch0_data, 32'ha1b2c3d4);
    chk("ch0 flag", {ch1_written, ch0_written}, 32'h1);
    ch(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 32'h0);
    chk("ch0 flag read", ch0_written, 32'h0);
    ch(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 32'h0f0f0f0f);
    chk("ch1 cpu data", ch1_data, 32'hf0f0f0f0);
    ch(1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 32'h0);
    chk("ch1 flag read", ch1_written, 32'h0);
    t_ch_b2b();
    ch(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 32'h55aa00ff);
    chk("write and read flag", ch0_written, 32'h1);
    ch(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 32'h13572468);
    chk("both write", ch1_data, 32'h13572468);
    t_crc();
    t_abort();
    delay <= 4'h0;
    boot_try('0, '0, 1'h0);
    boot_try(128'h1, 128'h2, 1'h0);
    boot_try(128'hc0de, 128'hc0de, 1'h1);
    chk("boot done", crc_done, 32'h1);
    exit_try(2'h1, 1'h0);
    exit_try(2'h2, 1'h1);
    @(posedge ref_clk);
    {sys_nrst, cold_plug} <= 2'h0;
    repeat (2) @(posedge ref_clk);
    sys_nrst <= 1'h1;
    #1;
    chk("sys reset release", cpu_release, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("warm release", cpu_release, 32'h1);
    chk("channel kept", ch0_data, 32'h55aa00ff);
    chk("flag kept", ch0_written, 32'h1);
    @(posedge ref_clk);
    nrst <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk("power reset channel", ch1_data, 32'h0);
    test_done();
  end
endmodule
